/* File: bench/vsc_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vsc_mem_model (
  input  wire logic        core_clk_i,
  input  wire logic        stall_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] data_i,
  input  wire logic        last_i,
  output logic             ready_o
);
  logic [31:0] addr_q[$];
  logic [31:0] data_q[$];
  int          lasts = 0;
  // Memory never starts a transfer; it only accepts or stalls
  assign ready_o = !stall_i;
  always @(posedge core_clk_i) begin
    if (valid_i && ready_o) begin
      addr_q.push_back(addr_i);
      data_q.push_back(data_i);
      if (last_i) lasts++;
    end
  end
endmodule // vsc_mem_model
`default_nettype wire

/* File: bench/vsc_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define M i_vsc_mem_model
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module vsc_top_tb_top;
  import vsc_pkg::*;
  localparam logic [31:0] TOPB = 32'h1000_0000;
  localparam logic [31:0] BOTB = 32'h2400_0000;
  localparam logic [31:0] STR  = 32'h0000_0400;
  localparam logic [31:0] C0   = 32'h0000_0b00;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, pci_en = 1'b1;
  logic        dclk = 1'b0, qual = 1'b0, hsync = 1'b0, vsync = 1'b0;
  logic        fbot = 1'b0, stall = 1'b0, pol = 1'b1;
  logic [31:0] avs_writedata_i = 32'h0, rdata, rd, addr, data;
  logic        wreq, valid, ready, last;
  logic [15:0] vid = 16'h0000;
  int          mismatches = 0, checks_done = 0, cyc = 0;

  vsc_top i_vsc_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .pci_master_en_i(pci_en), .double_rate_pixel_clock_i(dclk),
    .pixel_qualifier_i(qual), .vid_data_i(vid), .hsync_i(hsync),
    .vsync_i(vsync), .field_bottom_i(fbot), .dma_valid_o(valid),
    .dma_ready_i(ready), .dma_addr_o(addr), .dma_data_o(data),
    .dma_last_o(last));
  vsc_mem_model i_vsc_mem_model (.core_clk_i(core_clk_i), .stall_i(stall),
    .valid_i(valid), .addr_i(addr), .data_i(data), .last_i(last),
    .ready_o(ready));

  always #50 core_clk_i = ~core_clk_i;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic cyc_n(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic bus(input logic r, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_read_i <= r;
    avs_write_i <= !r;
    avs_writedata_i <= d;
    @(posedge core_clk_i);
    while (wreq !== 1'b0) @(posedge core_clk_i);
    rd = rdata;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // A decoy edge at the wrong qualifier level comes first each time
  task automatic pix(input logic [7:0] y);
    vid <= 16'h55aa;
    qual <= !pol;
    dclk <= 1'b1;
    cyc_n(3);
    dclk <= 1'b0;
    cyc_n(3);
    vid <= {8'h80, y};
    qual <= pol;
    dclk <= 1'b1;
    cyc_n(3);
    dclk <= 1'b0;
    cyc_n(3);
  endtask

  task automatic field(input logic b, input int nl, input int np);
    fbot <= b;
    vsync <= 1'b1;
    cyc_n(4);
    vsync <= 1'b0;
    cyc_n(4);
    for (int l = 0; l < nl; l++) begin
      hsync <= 1'b1;
      cyc_n(4);
      hsync <= 1'b0;
      cyc_n(4);
      for (int i = 0; i < np; i++) pix(8'(16 * l + i));
      cyc_n(8);
    end
  endtask

  // Parameters change only while output is off, rectangle set first
  task automatic cfg(input logic [31:0] ctl, scl, win);
    bus(1'b0, OFF_CTRL, 32'h0);
    bus(1'b0, OFF_SCALE, scl);
    bus(1'b0, OFF_WIN, win);
    bus(1'b0, OFF_TOP, TOPB);
    bus(1'b0, OFF_BOT, BOTB);
    bus(1'b0, OFF_STRIDE, STR);
    pol = ctl[CTL_POL];
    `M.addr_q.delete();
    `M.data_q.delete();
    `M.lasts = 0;
    bus(1'b0, OFF_CTRL, ctl | 32'h1);
  endtask

  task automatic expect_words(input int n, input string nm);
    int k;
    k = 0;
    while (`M.addr_q.size() < n && k < 2000) begin
      @(posedge core_clk_i);
      k++;
    end
    cyc_n(20);
    `CHK(nm, n, `M.addr_q.size())
  endtask

  task automatic t_regs;
    bus(1'b1, OFF_CTRL, 32'h0);
    `CHK("ctrl_reset", REG_RST, rd)
    bus(1'b1, OFF_WIN, 32'h0);
    `CHK("win_reset", REG_RST, rd)
    bus(1'b0, OFF_SCALE, 32'h0000_3f3f);
    bus(1'b1, OFF_SCALE, 32'h0);
    `CHK("scale_rw", 32'h0000_3f3f, rd)
    bus(1'b0, 5'h1c, 32'hffff_ffff);
    bus(1'b1, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test regs done");
  endtask

  task automatic t_enable;
    for (int k = 0; k < 2; k++) begin
      pci_en <= k[0];
      cfg(C0, 32'h0, {16'd1, 16'd4});
      if (k == 1) bus(1'b0, OFF_CTRL, C0);
      field(1'b0, 1, 4);
      expect_words(0, "words_disabled");
    end
    $display("test enable done");
  endtask

  task automatic t_fields;
    int f, l, w;
    logic [7:0] y;
    logic [31:0] ea;
    for (int d = 1; d >= 0; d--) begin
      cfg(d ? C0 : C0 ^ 32'h100, 32'h0, {16'd2, 16'd4});
      field(1'b0, 2, 4);
      field(1'b1, 2, 4);
      expect_words(d ? 8 : 4, "field_words");
      for (int i = 0; i < `M.addr_q.size(); i++) begin
        f = i / 4;
        l = (i / 2) % 2;
        w = i % 2;
        y = 8'(16 * l * w);
        ea = (f ? BOTB : TOPB) + 32'(l) * STR + 32'(4 * w);
        `CHK("addr", ea, `M.addr_q[i])
        ea = {y + 8'(w), 8'h0, y, 8'h0};
        `CHK("luma", ea, `M.data_q[i] & 32'hff00ff00)
      end
    end
    $display("test fields done");
  endtask

  // A luma ramp lands on the centre tap through 3- and 5-tap filters, one below it through 4-tap ones
  task automatic t_filter;
    for (int s = 1; s < 5; s++) begin
      cfg(C0 | (32'(s) << CTL_FLT), 32'h0, {16'd1, 16'd64});
      field(1'b0, 1, 64);
      expect_words(32, "filter_words");
      `CHK("ramp", s[0] ? 8'd20 : 8'd19, `M.data_q[11][15:8])
    end
    $display("test filter done");
  endtask

  task automatic t_formats;
    logic [11:0] fc[5] = '{12'h000, 12'h010, 12'h060, 12'h070, 12'h410};
    int          fw[5] = '{2, 4, 2, 2, 3};
    for (int k = 0; k < 5; k++) begin
      cfg({20'h0, fc[k]} | 32'h900, 32'h0, {16'd1, 16'd4});
      field(1'b0, 1, 4);
      expect_words(fw[k], "format_words");
      `CHK("line_end", 1, `M.lasts)
    end
    $display("test formats done");
  endtask

  task automatic t_hscale;
    int hd[3] = '{0, 32, 63};
    for (int k = 0; k < 3; k++) begin
      cfg(C0, 32'(hd[k]), {16'd1, 16'(64 - hd[k])});
      field(1'b0, 1, 64);
      expect_words((65 - hd[k]) / 2, "hdrop_words");
      if (k == 1)
        `CHK("spread", `M.data_q[1][15:8] + 8'd2, `M.data_q[1][31:24])
    end
    $display("test hscale done");
  endtask

  task automatic t_vscale;
    for (int d = 0; d < 2; d++) begin
      cfg(C0 | (32'(d) << CTL_DUP), 32'h2000, {16'd2, 16'd4});
      field(1'b0, 4, 4);
      field(1'b1, 4, 4);
      expect_words(8, "vdrop_words");
      `CHK("dup_pattern", 8'(16 * d), `M.data_q[5][15:8])
    end
    $display("test vscale done");
  endtask

  task automatic t_fifo;
    stall <= 1'b1;
    cfg(C0, 32'h0, {16'd1, 16'd32});
    field(1'b0, 1, 32);
    bus(1'b1, OFF_STAT, 32'h0);
    `CHK("fifo_full", 1'b1, rd[3])
    `CHK("held_words", 0, `M.addr_q.size())
    stall <= 1'b0;
    expect_words(16, "drained_words");
    `CHK("drain_last", 1, `M.lasts)
    bus(1'b1, OFF_STAT, 32'h0);
    `CHK("fifo_empty", 1'b0, rd[3])
    $display("test fifo done");
  endtask

  initial begin
    cyc_n(4);
    rst_i <= 1'b0;
    cyc_n(1);
    t_regs();
    t_enable();
    t_fields();
    t_filter();
    t_formats();
    t_hscale();
    t_vscale();
    t_fifo();
    end_sim();
  end
endmodule // vsc_top_tb_top
`default_nettype wire

/* File: logic/vsc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module vsc_fifo #(
  parameter int W = 36,
  parameter int D = 16
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         push;
  logic         pop;
  // Depth must be a power of two: the extra pointer bit tells full from empty
  assign in_ready_o  = ~((wp_r[AW] != rp_r[AW]) &&
                         (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid_o = (wp_r != rp_r);
  assign out_data_o  = mem_r[rp_r[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || flush_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + (AW+1)'(1);
      if (pop) rp_r <= rp_r + (AW+1)'(1);
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data_i;
  end
  fill_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wp_r - rp_r) <= (AW+1)'(D)) else $error("fifo fill beyond depth");
endmodule // vsc_fifo
`default_nettype wire

/* File: logic/vsc_hor_filter_select.sv */
`timescale 1ns/100ps
`default_nettype none
module vsc_hor_filter_select
  import vsc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       stb_i,
  input  wire logic [2:0] sel_i,
  input  wire logic [7:0] y_i,
  input  wire logic [7:0] c_i,
  output logic [7:0]      y_o,
  output logic [7:0]      c_o
);
  logic [7:0]  y_r [8];
  logic [7:0]  c_r [8];
  logic [11:0] ys;
  logic [11:0] cs;
  function automatic logic [11:0] e(input logic [7:0] x);
    e = {4'h0, x};
  endfunction
  // Chroma is interleaved U/V, so same-kind taps sit two samples apart
  for (genvar g = 0; g < 8; g++) begin : g_tap
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        y_r[g] <= 8'h00;
        c_r[g] <= 8'h80;
      end else if (stb_i) begin
        y_r[g] <= (g == 0) ? y_i : y_r[(g == 0) ? 0 : g-1];
        c_r[g] <= (g == 0) ? c_i : c_r[(g == 0) ? 0 : g-1];
      end
    end
  end
  // All sums are scaled to sixteenths so one shift normalises them
  always_comb begin
    unique case (vsc_flt_e'(sel_i))
      FLT_C3:   ys = {y_r[2], 4'h0}; // R01
      FLT_L3C3: ys = (e(y_r[1]) + e(y_r[2]) * 12'h2 + e(y_r[3])) * 12'h4;
      FLT_L4C4: ys = (e(y_r[1]) + (e(y_r[2]) + e(y_r[3])) * 12'h3 +
                      e(y_r[4])) * 12'h2; // R02
      FLT_L5C4: ys = e(y_r[0]) + (e(y_r[1]) + e(y_r[3])) * 12'h4 +
                     e(y_r[2]) * 12'h6 + e(y_r[4]);
      FLT_ALT4: ys = (e(y_r[1]) + e(y_r[2]) + e(y_r[3]) + e(y_r[4])) *
                     12'h4;
      default:  ys = {y_r[2], 4'h0};
    endcase
    unique case (vsc_flt_e'(sel_i))
      FLT_L4C4, FLT_L5C4: cs = (e(c_r[0]) + (e(c_r[2]) + e(c_r[4])) *
                               12'h3 + e(c_r[6])) * 12'h2; // R02
      FLT_ALT4: cs = (e(c_r[0]) + e(c_r[2]) + e(c_r[4]) + e(c_r[6])) *
                     12'h4;
      default:  cs = (e(c_r[0]) + e(c_r[2]) * 12'h2 + e(c_r[4])) *
                     12'h4; // R01
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      y_o <= 8'h00;
      c_o <= 8'h80;
    end else begin
      y_o <= ys[11:4];
      c_o <= cs[11:4];
    end
  end
endmodule // vsc_hor_filter_select
`default_nettype wire

/* File: logic/vsc_pkg.sv */
// Summary of operation
// R01 - Select 0/1: raw or 3-tap luma, 3-tap chroma
// R02 - Select 2/3/4: 4/5/4-tap luma, 4-tap chroma
// R03 - Drop count pixels out of every 64
// R04 - Drop count lines out of every 64
// R05 - Horizontal and vertical ratios act independently
// R06 - Duplicated-field mode shifts bottom drop pattern
// R07 - Format select: YUV, RGB888, RGB565, RGB555
// R08 - Error diffusion on or off
// R09 - Device masters the output bursts
// R10 - Output only with master and video enable
// R11 - Software keeps parameters while output enabled
// R12 - Field rectangle: base, stride, height, width
// R13 - Software programs rectangle before enabling
// R14 - Show both fields or top only
// R15 - Separate base per field, rectangles apart
// R16 - Sample when qualifier equals its polarity
// R17 - Packed 24-bit and byte order options
// R18 - Drops spread evenly over each group
`default_nettype none
package vsc_pkg;
  localparam logic [4:0]  OFF_CTRL   = 5'h00;
  localparam logic [4:0]  OFF_SCALE  = 5'h04;
  localparam logic [4:0]  OFF_TOP    = 5'h08;
  localparam logic [4:0]  OFF_BOT    = 5'h0c;
  localparam logic [4:0]  OFF_STRIDE = 5'h10;
  localparam logic [4:0]  OFF_WIN    = 5'h14;
  localparam logic [4:0]  OFF_STAT   = 5'h18;
  localparam logic [31:0] REG_RST    = 32'h0000_0000;
  localparam int CTL_EN   = 0;
  localparam int CTL_FLT  = 1;
  localparam int CTL_CCS  = 4;
  localparam int CTL_ERR  = 6;
  localparam int CTL_DUP  = 7;
  localparam int CTL_DISP = 8;
  localparam int CTL_POL  = 9;
  localparam int CTL_PK24 = 10;
  localparam int CTL_LOW  = 11;
  localparam int SCL_HOR  = 0;
  localparam int SCL_VER  = 8;
  localparam int WIN_WID  = 0;
  localparam int WIN_HT   = 16;
  localparam int STA_OVF  = 2;
  localparam int WB_EOL   = 32;
  localparam int WB_SOL   = 33;
  localparam int WB_SOF   = 34;
  localparam int WB_BOT   = 35;
  localparam int FIFO_W   = 36;
  localparam int FIFO_D   = 16;
  localparam logic [5:0] DUP_OFFSET = 6'h20;
  typedef enum logic [1:0] {
    CCS_YUV = 2'h0, CCS_RGB888 = 2'h1, CCS_RGB565 = 2'h2, CCS_RGB555 = 2'h3
  } vsc_ccs_e;
  typedef enum logic [2:0] {
    FLT_C3 = 3'h0, FLT_L3C3 = 3'h1, FLT_L4C4 = 3'h2, FLT_L5C4 = 3'h3,
    FLT_ALT4 = 3'h4
  } vsc_flt_e;
endpackage
`default_nettype wire

/* File: logic/vsc_top.sv */
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module vsc_top
  import vsc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        pci_master_en_i,
  input  wire logic        double_rate_pixel_clock_i,
  input  wire logic        pixel_qualifier_i,
  input  wire logic [15:0] vid_data_i,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  input  wire logic        field_bottom_i,
  output logic             dma_valid_o,
  input  wire logic        dma_ready_i,
  output logic [31:0]      dma_addr_o,
  output logic [31:0]      dma_data_o,
  output logic             dma_last_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] ctrl_r;
  logic [31:0] scale_r;
  logic [31:0] top_r;
  logic [31:0] bot_r;
  logic [31:0] stride_r;
  logic [31:0] win_r;
  logic        rd_done_r;
  logic        ovf_r;
  logic        act;
  logic        pol;
  logic        dup;
  logic        ed;
  logic        pk24;
  logic        low_first;
  logic        disp_both;
  vsc_ccs_e    ccs;
  logic [5:0]  hdrop;
  logic [5:0]  vdrop;
  logic [9:0]  wwid;
  logic [9:0]  whgt;

  assign act       = ctrl_r[CTL_EN] & pci_master_en_i; // R10
  assign ccs       = vsc_ccs_e'(ctrl_r[CTL_CCS +: 2]);
  assign ed        = ctrl_r[CTL_ERR];
  assign dup       = ctrl_r[CTL_DUP];
  assign disp_both = ctrl_r[CTL_DISP];
  assign pol       = ctrl_r[CTL_POL];
  assign pk24      = ctrl_r[CTL_PK24];
  assign low_first = ctrl_r[CTL_LOW];
  assign hdrop     = scale_r[SCL_HOR +: 6];
  assign vdrop     = scale_r[SCL_VER +: 6];
  assign wwid      = win_r[WIN_WID +: 10];
  assign whgt      = win_r[WIN_HT +: 10];

  // Parameters are used live; software holds them while output runs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r   <= REG_RST;
      scale_r  <= REG_RST;
      top_r    <= REG_RST;
      bot_r    <= REG_RST;
      stride_r <= REG_RST;
      win_r    <= REG_RST;
    end else if (avs_write_i) begin
      case (avs_address_i[4:2])
        OFF_CTRL[4:2]:   ctrl_r   <= avs_writedata_i;
        OFF_SCALE[4:2]:  scale_r  <= avs_writedata_i;
        OFF_TOP[4:2]:    top_r    <= avs_writedata_i; // R12 R15
        OFF_BOT[4:2]:    bot_r    <= avs_writedata_i; // R15
        OFF_STRIDE[4:2]: stride_r <= avs_writedata_i;
        OFF_WIN[4:2]:    win_r    <= avs_writedata_i;
        default: ;
      endcase
    end
  end

  // Input pins: two-stage synchroniser, edges taken from the second stage
  logic [20:0] s1_r;
  logic [20:0] s2_r;
  logic [2:0]  prv_r;
  logic        line_stb;
  logic        field_stb;
  logic        pix_stb;
  logic        field_on_r;
  logic        line_keep_r;
  logic        fld_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_r  <= 21'h0;
      s2_r  <= 21'h0;
      prv_r <= 3'h0;
    end else begin
      s1_r  <= {vid_data_i, field_bottom_i, vsync_i, hsync_i,
                pixel_qualifier_i, double_rate_pixel_clock_i};
      s2_r  <= s1_r;
      prv_r <= {s2_r[3], s2_r[2], s2_r[0]};
    end
  end
  assign line_stb  = s2_r[2] & ~prv_r[1];
  assign field_stb = s2_r[3] & ~prv_r[2];
  assign pix_stb   = s2_r[0] & ~prv_r[0] & (s2_r[1] == pol) & act &
                     field_on_r & line_keep_r; // R16

  // Vertical scaler: its own accumulator, reset per field
  logic [5:0] vacc_r;
  logic [9:0] line_cnt_r;
  logic [6:0] vsum;
  logic [9:0] lc;
  assign vsum = {1'b0, vacc_r} + {1'b0, vdrop};
  assign lc   = line_cnt_r + {9'h0, line_keep_r};
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vacc_r      <= 6'h00;
      line_cnt_r  <= 10'h000;
      line_keep_r <= 1'b0;
      field_on_r  <= 1'b0;
      fld_r       <= 1'b0;
    end else if (field_stb) begin
      field_on_r  <= act & (disp_both | ~s2_r[4]); // R14
      fld_r       <= s2_r[4];
      vacc_r      <= (dup & s2_r[4]) ? DUP_OFFSET : 6'h00; // R06
      line_cnt_r  <= 10'h000;
      line_keep_r <= 1'b0;
    end else if (line_stb) begin
      vacc_r      <= vsum[5:0]; // R04 R05 R18
      line_cnt_r  <= lc;
      line_keep_r <= ~vsum[6] & (lc < whgt) & field_on_r & act; // R12
    end
  end

  logic [7:0] fy;
  logic [7:0] fc;
  logic [1:0] stb_d_r;
  logic       f_stb;
  // Taps clear at each line start so no pixel leaks into the next line
  vsc_hor_filter_select u_filt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i | line_stb),
    .stb_i      (pix_stb),
    .sel_i      (ctrl_r[CTL_FLT +: 3]),
    .y_i        (s2_r[12:5]),
    .c_i        (s2_r[20:13]),
    .y_o        (fy),
    .c_o        (fc)
  );
  always_ff @(posedge core_clk_i) begin
    if (rst_i) stb_d_r <= 2'h0;
    else stb_d_r <= {stb_d_r[0], pix_stb};
  end
  assign f_stb = stb_d_r[1];

  // Horizontal scaler: accumulator overflow marks a dropped pixel
  logic [5:0] hacc_r;
  logic [6:0] hsum;
  logic [9:0] pix_cnt_r;
  logic       hkeep;
  logic       can_acc;
  logic       take;
  logic       last;
  logic       phase_r;
  logic       opar_r;
  logic [7:0] u_r;
  logic [7:0] v_r;
  logic [7:0] uu;
  logic [7:0] vv;
  assign hsum  = {1'b0, hacc_r} + {1'b0, hdrop};
  assign hkeep = ~hsum[6] & (pix_cnt_r < wwid); // R03 R18
  assign take  = f_stb & hkeep & can_acc;
  assign last  = (pix_cnt_r == wwid - 10'h001);
  assign uu    = phase_r ? u_r : fc;
  assign vv    = phase_r ? fc : v_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || line_stb) begin
      hacc_r    <= 6'h00;
      pix_cnt_r <= 10'h000;
      phase_r   <= 1'b0;
      opar_r    <= 1'b0;
      u_r       <= 8'h80;
      v_r       <= 8'h80;
    end else if (f_stb) begin
      hacc_r  <= hsum[5:0]; // R03 R05
      phase_r <= ~phase_r;
      if (phase_r) v_r <= fc;
      else u_r <= fc;
      if (take) begin
        pix_cnt_r <= pix_cnt_r + 10'h001;
        opar_r    <= ~opar_r;
      end
    end
  end

  // Colour conversion; residue of the last pixel is fed forward
  logic signed [19:0] du;
  logic signed [19:0] dv;
  logic signed [19:0] yw;
  logic signed [19:0] rw;
  logic signed [19:0] gw;
  logic signed [19:0] bw;
  logic [7:0]  r8;
  logic [7:0]  g8;
  logic [7:0]  b8;
  logic [2:0]  er_r;
  logic [2:0]  eg_r;
  logic [2:0]  eb_r;
  logic        dif;
  logic [31:0] px;
  logic [2:0]  nb;
  function automatic logic [7:0] sat(input logic signed [19:0] x);
    if (x < 20'sh00000) sat = 8'h00;
    else if (x > 20'sh0ffff) sat = 8'hff;
    else sat = x[15:8];
  endfunction
  assign du = $signed({12'h000, uu}) - 20'sh00080;
  assign dv = $signed({12'h000, vv}) - 20'sh00080;
  assign yw = $signed({4'h0, fy, 8'h00});
  assign rw = yw + 20'sh00167 * dv + $signed({9'h000, er_r, 8'h00});
  assign gw = yw - 20'sh00058 * du - 20'sh000b7 * dv +
              $signed({9'h000, eg_r, 8'h00});
  assign bw = yw + 20'sh001c6 * du + $signed({9'h000, eb_r, 8'h00});
  assign r8 = sat(rw);
  assign g8 = sat(gw);
  assign b8 = sat(bw);
  assign dif = ed & ccs[1]; // R08
  always_ff @(posedge core_clk_i) begin
    if (rst_i || line_stb) begin
      er_r <= 3'h0;
      eg_r <= 3'h0;
      eb_r <= 3'h0;
    end else if (take) begin
      er_r <= dif ? r8[2:0] : 3'h0; // R08
      eg_r <= dif ? (ccs == CCS_RGB565 ? {1'b0, g8[1:0]} : g8[2:0])
                  : 3'h0;
      eb_r <= dif ? b8[2:0] : 3'h0;
    end
  end
  always_comb begin
    px = 32'h0;
    nb = 3'h2;
    unique case (ccs) // R07
      CCS_YUV:    px = {16'h0, fy, opar_r ? vv : uu};
      CCS_RGB565: px = {16'h0, r8[7:3], g8[7:2], b8[7:3]};
      CCS_RGB555: px = {17'h0, r8[7:3], g8[7:3], b8[7:3]};
      CCS_RGB888: begin
        px = {8'h0, r8, g8, b8};
        nb = pk24 ? 3'h3 : 3'h4; // R17
      end
    endcase
    if (!low_first && !(ccs == CCS_RGB888 && pk24)) begin // R17
      if (nb == 3'h4) px = {px[7:0], px[15:8], px[23:16], px[31:24]};
      else px = {16'h0, px[7:0], px[15:8]};
    end
  end

  // Byte packer; the first pixel of each line starts a fresh word
  logic [55:0] acc_r;
  logic [55:0] acc_sh;
  logic [2:0]  cnt_r;
  logic [3:0]  csum;
  logic        emit;
  logic [35:0] wr_r;
  logic        wv_r;
  logic        sof_r;
  logic        sol_r;
  logic        fin_ready;
  assign acc_sh  = acc_r | ({24'h0, px} << {cnt_r, 3'h0});
  assign csum    = {1'b0, cnt_r} + {1'b0, nb};
  assign emit    = take & ((csum >= 4'h4) | last);
  assign can_acc = ~wv_r | fin_ready;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || line_stb) begin
      acc_r <= 56'h0;
      cnt_r <= 3'h0;
    end else if (take) begin
      if (last) begin
        acc_r <= 56'h0;
        cnt_r <= 3'h0;
      end else if (csum >= 4'h4) begin
        acc_r <= {32'h0, acc_sh[55:32]};
        cnt_r <= {1'b0, csum[1:0]};
      end else begin
        acc_r <= acc_sh;
        cnt_r <= csum[2:0];
      end
    end
  end
  // A pixel that finds the word register still full is lost, not stalled
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_r  <= 36'h0;
      wv_r  <= 1'b0;
      sof_r <= 1'b0;
      sol_r <= 1'b0;
    end else begin
      if (emit) begin
        wr_r <= {fld_r, sof_r, sol_r, last, acc_sh[31:0]};
        wv_r <= 1'b1;
      end else if (fin_ready) begin
        wv_r <= 1'b0;
      end
      if (field_stb) sof_r <= 1'b1;
      else if (emit) sof_r <= 1'b0;
      if (line_stb) sol_r <= 1'b1;
      else if (emit) sol_r <= 1'b0;
    end
  end

  // Output side: bursts of words towards memory
  logic [35:0] fo;
  logic        fo_valid;
  logic        pop;
  logic [31:0] waddr_r;
  logic [31:0] nline_r;
  vsc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .flush_i     (~act),
    .in_valid_i  (wv_r),
    .in_ready_o  (fin_ready),
    .in_data_i   (wr_r),
    .out_valid_o (fo_valid),
    .out_ready_i (dma_ready_i & act),
    .out_data_o  (fo)
  );
  assign dma_valid_o = fo_valid & act; // R09 R10
  assign dma_data_o  = fo[31:0];
  assign dma_last_o  = fo[WB_EOL] & dma_valid_o;
  assign dma_addr_o  = fo[WB_SOF] ? (fo[WB_BOT] ? bot_r : top_r) :
                       fo[WB_SOL] ? nline_r : waddr_r; // R12 R15
  assign pop         = dma_valid_o & dma_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      waddr_r <= 32'h0;
      nline_r <= 32'h0;
    end else if (pop) begin
      waddr_r <= dma_addr_o + 32'h4;
      if (fo[WB_SOL]) nline_r <= dma_addr_o + stride_r; // R12
    end
  end

  // Register reads take one wait cycle; overflow clears on write of one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) ovf_r <= 1'b0;
    else if (f_stb & hkeep & ~can_acc) ovf_r <= 1'b1;
    else if (avs_write_i && avs_address_i[4:2] == OFF_STAT[4:2] &&
             avs_writedata_i[STA_OVF]) ovf_r <= 1'b0;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_done_r      <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      rd_done_r <= avs_read_i & ~rd_done_r;
      if (avs_read_i && !rd_done_r) begin
        case (avs_address_i[4:2])
          OFF_CTRL[4:2]:   avs_readdata_o <= ctrl_r;
          OFF_SCALE[4:2]:  avs_readdata_o <= scale_r;
          OFF_TOP[4:2]:    avs_readdata_o <= top_r;
          OFF_BOT[4:2]:    avs_readdata_o <= bot_r;
          OFF_STRIDE[4:2]: avs_readdata_o <= stride_r;
          OFF_WIN[4:2]:    avs_readdata_o <= win_r;
          OFF_STAT[4:2]:   avs_readdata_o <= {6'h00, line_cnt_r, 12'h000,
                                              ~fin_ready, ovf_r, fld_r, act};
          default:         avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end
  assign avs_waitrequest_o = avs_read_i & ~rd_done_r;

  // Helper: drops counted over each group of 64 input pixels
  logic [5:0] g_in_r;
  logic [6:0] g_dr_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || line_stb) begin
      g_in_r <= 6'h00;
      g_dr_r <= 7'h00;
    end else if (f_stb) begin
      g_in_r <= g_in_r + 6'h01;
      g_dr_r <= (g_in_r == 6'h3f) ? 7'h00 : g_dr_r + {6'h00, hsum[6]};
    end
  end
  sequence s_bot_start;
    field_stb && s2_r[4];
  endsequence
  sequence s_line_pop;
    pop && fo[WB_SOL];
  endsequence
  hgrp_ratio_a: assert property ( // R03
    f_stb && g_in_r == 6'h3f |-> g_dr_r + {6'h00, hsum[6]} == {1'b0, hdrop})
    else $error("drop count per 64 pixels wrong");
  hzero_pass_a: assert property ( // R03
    f_stb && hdrop == 6'h00 && pix_cnt_r < wwid && can_acc && !line_stb
    |=> pix_cnt_r == $past(pix_cnt_r) + 10'h001)
    else $error("pixel dropped with zero count");
  vzero_keep_a: assert property ( // R04
    line_stb && !field_stb && vdrop == 6'h00 && field_on_r && act &&
    lc < whgt |=> line_keep_r)
    else $error("line dropped with zero count");
  dup_phase_a: assert property ( // R06
    s_bot_start |=> vacc_r == ($past(dup) ? DUP_OFFSET : 6'h00))
    else $error("bottom field drop phase wrong");
  top_only_a: assert property ( // R14
    field_stb && !disp_both && s2_r[4] |=> !field_on_r ##1 !pix_stb)
    else $error("bottom field captured in top-only mode");
  qual_match_a: assert property ( // R16
    pix_stb |-> s2_r[1] == pol ##2 f_stb)
    else $error("pixel sampled on wrong qualifier");
  dma_idle_a: assert property ( // R10
    !act |-> !dma_valid_o)
    else $error("output active while disabled");
  dma_hold_a: assert property ( // R09
    dma_valid_o && !dma_ready_i |=> !act || (dma_valid_o &&
    $stable(dma_data_o) && $stable(dma_addr_o)))
    else $error("burst word changed before taken");
  line_step_a: assert property ( // R12
    s_line_pop |=> nline_r == $past(dma_addr_o) + stride_r)
    else $error("next line address not base plus stride");
  pack_size_a: assert property ( // R17
    take && ccs == CCS_RGB888 |-> emit == (last || !pk24 || cnt_r != 3'h0))
    else $error("24-bit pixel packing cadence wrong");
endmodule // vsc_top
`default_nettype wire
